// *** rtl/adc_seq_defs.vh ***
// Register offsets, field layout and timing figures of the mode sequencer
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH

// Register byte offsets
`define OFS_MODE 8'h00
`define OFS_ACQ 8'h04
`define OFS_PWRUP 8'h08
`define OFS_INTCFG 8'h0C
`define OFS_STATUS 8'h10
`define OFS_RESULT0 8'h20
`define OFS_RESULT3 8'h2C

// Mode control fields
`define MODE_LSB 0
`define MODE_MSB 2
`define CHSEL_LSB 4
`define CHSEL_MSB 5

// Mode codes
`define MODE_IDLE 3'h0
`define MODE_AWAKE 3'h1
`define MODE_MSINGLE 3'h2
`define MODE_MSCAN 3'h3
`define MODE_ASINGLE 3'h4
`define MODE_ASCAN 3'h5

// Interrupt configuration fields
`define INTSRC_LSB 0
`define INTSRC_MSB 1
`define INTCFG_EACH 2
`define INTCFG_HALT 3
`define INTSRC_BUSY 2'h0
`define INTSRC_READY 2'h1
`define INTSRC_ALARM 2'h2

// Reset values
`define MODE_RST 8'h00
`define DELAY_RST 5'h00
`define INTCFG_RST 4'h1

// Timing in nanoseconds
`define T_STEP_NS 2000
`define ACQUISITION_DELAY_MIN_NS 6000
`define T_CONV_NS 4000
`define OSC_PERIOD_NS 160

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** rtl/adc_mode_sequencer.v ***
// Conversion sequencer of a four-channel converter with AXI4-Lite registers
`timescale 1ns/1ps
`include "adc_seq_defs.vh"

module adc_mode_sequencer #(
   parameter OSC_PERIOD_NS = `OSC_PERIOD_NS,
   parameter RES_W = 12
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire osc_clk,
   input wire [RES_W-1:0] adc_result,
   input wire alarm_trip,
   output reg analog_power_on,
   output reg external_amp_power_out,
   output reg [1:0] mux_channel,
   output reg sample_on,
   output reg busy,
   output reg data_ready,
   output reg int_n
);

   // Tick counts, least times rounded up
   // Rounding up keeps every phase except the first after a mode write at least its nominal length
   localparam integer STEP_INT = (`T_STEP_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
   localparam integer ACQ_MIN_INT = (`ACQUISITION_DELAY_MIN_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
   localparam integer CONV_INT = (`T_CONV_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
   // Ten bits hold the longest count the five-bit fields can ask for;
   // a much faster oscillator would need a wider phase counter
   localparam [9:0] STEP_TICKS = STEP_INT[9:0];
   localparam [9:0] ACQ_MIN_TICKS = ACQ_MIN_INT[9:0];
   localparam [9:0] CONV_TICKS = CONV_INT[9:0];

   // One-hot sequencer states
   localparam [4:0] ST_OFF = 5'b0_0001;
   localparam [4:0] ST_WAIT = 5'b0_0010;
   localparam [4:0] ST_PWRUP = 5'b0_0100;
   localparam [4:0] ST_ACQ = 5'b0_1000;
   localparam [4:0] ST_CONV = 5'b1_0000;

   ////////////////////////////////////////////////////////////////////////
   // Registers and state

   reg [7:0] mode_control_reg_q;
   reg [4:0] acquisition_delay_field_q;
   reg [4:0] powerup_delay_field_q;
   reg [3:0] int_cfg_q;
   reg [RES_W-1:0] result_q [0:3];
   reg [4:0] state_q;
   reg [9:0] cnt_q;
   reg [1:0] left_q;
   reg skip_pu_q;
   reg aw_held_q;
   reg w_held_q;
   reg [7:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg osc_s1_q;
   reg osc_s2_q;
   reg osc_s3_q;
   reg mode_go_q;
   integer i;

   // Decoded fields and strobes; a mode write acts only on its response handshake
   wire [2:0] mode = mode_control_reg_q[`MODE_MSB:`MODE_LSB];
   wire [1:0] chsel = mode_control_reg_q[`CHSEL_MSB:`CHSEL_LSB];
   wire tick = osc_s2_q & ~osc_s3_q;
   wire wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
   wire wr_mode = wr_fire & (aw_addr_q == `OFS_MODE) & w_strb_q[0];
   wire b_done = s_axi_bvalid & s_axi_bready;
   wire rd_fire = s_axi_arvalid & s_axi_arready;
   wire rd_result = rd_fire & (s_axi_araddr >= `OFS_RESULT0) &
      (s_axi_araddr <= `OFS_RESULT3) & (s_axi_araddr[1:0] == 2'b00);
   wire [9:0] acq_ticks =
      {5'h00, acquisition_delay_field_q} * STEP_TICKS + ACQ_MIN_TICKS;
   wire [9:0] pu_ticks = {5'h00, powerup_delay_field_q} * STEP_TICKS;
   wire cnt_end = tick & (cnt_q == 10'h001);
   wire halt_now = int_cfg_q[`INTCFG_HALT] & alarm_trip;

   ////////////////////////////////////////////////////////////////////////
   // Oscillator pin: two synchronising stages, then an edge detector

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
      end else begin
         osc_s1_q <= osc_clk;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken in either order

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_held_q & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready <= ~w_held_q & ~s_axi_wready & ~s_axi_bvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (aw_addr_q)
               `OFS_MODE, `OFS_ACQ, `OFS_PWRUP, `OFS_INTCFG:
                  s_axi_bresp <= `RESP_OKAY;
               default: s_axi_bresp <= `RESP_SLVERR;
            endcase
         end else if (b_done) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register stores; only byte lane 0 carries fields
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         mode_control_reg_q <= `MODE_RST;
         acquisition_delay_field_q <= `DELAY_RST;
         powerup_delay_field_q <= `DELAY_RST;
         int_cfg_q <= `INTCFG_RST;
         mode_go_q <= 1'b0;
      end else begin
         if (wr_fire & w_strb_q[0]) begin
            case (aw_addr_q)
               `OFS_MODE: mode_control_reg_q <= w_data_q[7:0];
               `OFS_ACQ: acquisition_delay_field_q <= w_data_q[4:0];
               `OFS_PWRUP: powerup_delay_field_q <= w_data_q[4:0];
               `OFS_INTCFG: int_cfg_q <= w_data_q[3:0];
               default: ;
            endcase
         end
         // Mode acts once the write is acknowledged, like the ack edge
         if (wr_mode)
            mode_go_q <= 1'b1;
         else if (b_done)
            mode_go_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel: answer one cycle after the address is taken

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            case (s_axi_araddr)
               `OFS_MODE: s_axi_rdata[7:0] <= mode_control_reg_q;
               `OFS_ACQ: s_axi_rdata[4:0] <= acquisition_delay_field_q;
               `OFS_PWRUP: s_axi_rdata[4:0] <= powerup_delay_field_q;
               `OFS_INTCFG: s_axi_rdata[3:0] <= int_cfg_q;
               // Bit 1 is spare so ready and busy keep their places
               `OFS_STATUS:
                  s_axi_rdata[9:0] <= {state_q, mux_channel, data_ready, 1'b0, busy};
               default: begin
                  if (rd_result)
                     s_axi_rdata[RES_W-1:0] <= result_q[s_axi_araddr[3:2]];
                  else
                     s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         state_q <= ST_OFF;
         cnt_q <= 10'h000;
         left_q <= 2'h0;
         mux_channel <= 2'h0;
         skip_pu_q <= 1'b0;
         for (i = 0; i < 4; i = i + 1)
            result_q[i] <= {RES_W{1'b0}};
      end else if (mode_go_q & b_done) begin
         // New mode acts at once; any running sequence is dropped
         // Idle and awake keep the channel, so an abort never moves the
         // multiplexer while the sample capacitor is still connected
         left_q <= 2'h3;
         case (mode)
            `MODE_IDLE: begin
               state_q <= ST_OFF;
               skip_pu_q <= 1'b0;
            end
            `MODE_MSINGLE, `MODE_MSCAN, `MODE_ASINGLE, `MODE_ASCAN: begin
               mux_channel <= chsel;
               // Only a zero power-up delay or a repeated manual command skips power-up
               if (pu_ticks == 10'h000 | (skip_pu_q & (mode == `MODE_MSINGLE |
                  mode == `MODE_MSCAN))) begin
                  state_q <= ST_ACQ;
                  cnt_q <= acq_ticks;
               end else begin
                  state_q <= ST_PWRUP;
                  cnt_q <= pu_ticks;
               end
            end
            default: begin
               state_q <= ST_WAIT;
               skip_pu_q <= 1'b0;
            end
         endcase
      end else begin
         if (tick & cnt_q != 10'h000)
            cnt_q <= cnt_q - 10'h001;
         case (state_q)
            ST_PWRUP: begin
               if (cnt_end) begin
                  state_q <= ST_ACQ;
                  cnt_q <= acq_ticks;
               end
            end
            ST_ACQ: begin
               if (cnt_end) begin
                  state_q <= ST_CONV;
                  cnt_q <= CONV_TICKS;
               end
            end
            ST_CONV: begin
               if (cnt_end) begin
                  result_q[mux_channel] <= adc_result;
                  cnt_q <= acq_ticks;
                  state_q <= ST_ACQ;
                  case (mode)
                     `MODE_MSINGLE: begin
                        state_q <= ST_WAIT;
                        skip_pu_q <= 1'b1;
                     end
                     `MODE_MSCAN: begin
                        if (left_q == 2'h0) begin
                           state_q <= ST_WAIT;
                           skip_pu_q <= 1'b1;
                        end else begin
                           left_q <= left_q - 2'h1;
                           mux_channel <= mux_channel + 2'h1;
                        end
                     end
                     `MODE_ASINGLE: begin
                        if (halt_now)
                           state_q <= ST_WAIT;
                     end
                     `MODE_ASCAN: begin
                        mux_channel <= mux_channel + 2'h1;
                        if (halt_now)
                           state_q <= ST_WAIT;
                     end
                     default: state_q <= ST_WAIT;
                  endcase
               end
            end
            ST_OFF, ST_WAIT: ;
            default: state_q <= ST_OFF;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status, power and interrupt outputs

   // End of each conversion and of the run (every conversion in auto modes), used for data ready
   wire conv_done = (state_q == ST_CONV) & cnt_end & ~(mode_go_q & b_done);
   wire run_done = conv_done & ((mode == `MODE_MSINGLE) |
      ((mode == `MODE_MSCAN) & (left_q == 2'h0)) | (mode == `MODE_ASINGLE) |
      (mode == `MODE_ASCAN));
   wire ready_set = int_cfg_q[`INTCFG_EACH] ? conv_done : run_done;

   // Ready is sticky; a new result wins over a clearing read
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         data_ready <= 1'b0;
         busy <= 1'b0;
         sample_on <= 1'b0;
         analog_power_on <= 1'b0;
         external_amp_power_out <= 1'b0;
         int_n <= 1'b1;
      end else begin
         if (ready_set)
            data_ready <= 1'b1;
         else if (rd_result | (mode_go_q & b_done))
            data_ready <= 1'b0;
         busy <= (state_q == ST_CONV) & ~cnt_end;
         sample_on <= (state_q == ST_ACQ);
         analog_power_on <= (state_q != ST_OFF);
         external_amp_power_out <=
            (state_q == ST_PWRUP) | (state_q == ST_ACQ) | (state_q == ST_CONV);
         case (int_cfg_q[`INTSRC_MSB:`INTSRC_LSB])
            `INTSRC_BUSY: int_n <= ~busy;
            `INTSRC_READY: int_n <= ~data_ready;
            `INTSRC_ALARM: int_n <= ~alarm_trip;
            default: int_n <= 1'b1;
         endcase
      end
   end

endmodule // adc_mode_sequencer

// *** bench/adc_core_model.sv ***
// Converter core and oscillator model facing the mode sequencer
`timescale 1ns/1ps
module adc_core_model (
   input wire sys_clk,
   input wire [1:0] mux_channel,
   input wire busy,
   output logic osc_clk,
   output logic [11:0] adc_result
);
   logic [11:0] noise_q = 12'h000;
   ////////////////////////////////////////////////////////////////////////////////
   // Free-running oscillator, phase unrelated to the system clock
   initial begin
      osc_clk = 1'b0;
      #3;
      forever #80 osc_clk = ~osc_clk;
   end
   // Outside a conversion the bus moves every cycle, so a stale sample shows up
   always @(posedge sys_clk) noise_q <= noise_q + 12'h5A5;
   // A converted channel reads as a fixed base plus its number
   assign adc_result = (busy === 1'b1) ? 12'h5A0 + {10'h000, mux_channel} : noise_q;
endmodule // adc_core_model

// *** bench/adc_seq_monitor.sv ***
// Concurrent checks on the ports of the mode sequencer
`timescale 1ns/1ps
module adc_seq_monitor #(
   parameter OSC_PERIOD_NS = 160
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire analog_power_on,
   input wire external_amp_power_out,
   input wire [1:0] mux_channel,
   input wire sample_on,
   input wire busy,
   input wire data_ready
);
   localparam int CONV_CYC = 25 * OSC_PERIOD_NS / 10;
   logic [11:0] busy_len_q;
   logic cut_q;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // Busy run length; a mode write inside a run is an abort and may cut it short
   always @(posedge sys_clk) begin
      busy_len_q <= (sys_rst || !busy) ? 12'h000 : busy_len_q + 12'h001;
      cut_q <= busy && (cut_q || (s_axi_bvalid && s_axi_bready));
   end
   // Bus transfers taken on an edge
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_wr_answer: assert property (s_wr_taken |=> ##1 s_axi_bvalid)
      else $error("write response missing");
   a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
      else $error("read response missing");
   a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("address ready longer than one cycle");
   a_conv_len: assert property ($fell(busy) && !cut_q |->
      busy_len_q >= CONV_CYC - 2 && busy_len_q <= CONV_CYC + 2)
      else $error("conversion length wrong");
   a_amp_conv: assert property ($rose(busy) |-> external_amp_power_out)
      else $error("amplifier power off at conversion");
   a_pwr_conv: assert property ($rose(busy) |-> analog_power_on)
      else $error("conversion while powered down");
   a_mux_steady: assert property (sample_on && $past(sample_on) |-> $stable(mux_channel))
      else $error("channel moved during acquisition");
   a_ready_cause: assert property ($rose(data_ready) |-> busy || $past(busy))
      else $error("data ready without a conversion");
endmodule // adc_seq_monitor

bind adc_mode_sequencer adc_seq_monitor #(.OSC_PERIOD_NS(OSC_PERIOD_NS)) adc_seq_monitor_i (.*);

// *** bench/adc_mode_sequencer_tb_top.sv ***
// Self-checking bench of the mode sequencer: register tasks and mode scenarios
`timescale 1ns/1ps
`include "adc_seq_defs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end
module adc_mode_sequencer_tb_top;
   logic sys_clk, sys_rst = 1'b1, alarm_trip = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, mux_channel, r, br;
   logic osc_clk, analog_power_on, external_amp_power_out, sample_on, busy, data_ready, int_n;
   logic [11:0] adc_result;
   int errors = 0, checks = 0, n, k;
   adc_mode_sequencer adc_mode_sequencer_i (.*);
   adc_core_model adc_core_model_i (.*);
   ////////////////////////////////////////////////////////////////////////////////
   // System clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      br = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Read one word and its response code
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      v = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge sys_clk);
   endtask
   function automatic logic [31:0] mw(input logic [1:0] c, input logic [2:0] m);
      return {26'h000_0000, c, 1'b0, m};
   endfunction
   // Cycles until busy rises; a conversion still running is waited out first
   task automatic wait_busy(output int c);
      c = 0;
      while (busy === 1'b1) @(posedge sys_clk);
      while (busy !== 1'b1 && c < 20000) begin
         @(posedge sys_clk);
         c++;
      end
   endtask
   // Cycles that busy stays high
   task automatic wait_idle(output int c);
      c = 0;
      while (busy === 1'b1 && c < 2000) begin
         @(posedge sys_clk);
         c++;
      end
   endtask
   // Busy rises seen within a span
   task automatic count_busy(input int span, output int c);
      logic p;
      c = 0;
      p = busy;
      repeat (span) begin
         @(posedge sys_clk);
         if (busy === 1'b1 && p !== 1'b1) c++;
         p = busy;
      end
   endtask
   task test_done;
      if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard, well beyond the expected run
   initial begin
      #600000;
      errors++;
      test_done;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios; run modes start from awake, except the reissued manual single
   initial begin
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      `CHK("power_rst", 1'b0, analog_power_on)
      `CHK("int_rst", 1'b1, int_n)
      rd(`OFS_INTCFG, d, r);
      `CHK("intcfg_rst", 32'h0000_0001, d)
      rd(8'h40, d, r);
      `CHK("unmapped", `RESP_SLVERR, r)
      `CHK("unmapped_data", 32'h0000_0000, d)
      wr(8'h40, 32'h0000_0001);
      `CHK("wr_unmapped", `RESP_SLVERR, br)
      wr(`OFS_PWRUP, 32'h0000_0002);
      `CHK("wr_resp", `RESP_OKAY, br)
      wr(`OFS_ACQ, 32'h0000_0001);
      wr(`OFS_MODE, mw(2'h0, `MODE_AWAKE));
      count_busy(1000, k);
      `CHK("awake_quiet", 0, k)
      `CHK("awake_power", 1'b1, analog_power_on)
      wr(`OFS_MODE, mw(2'h1, `MODE_MSINGLE));
      repeat (2) @(posedge sys_clk);
      `CHK("pwrup_amp", 1'b1, external_amp_power_out)
      `CHK("pwrup_nosample", 1'b0, sample_on)
      wait_busy(n);
      `CHK("single_delay", 1'b1, n inside {[1200:1280]})
      `CHK("single_chan", 2'h1, mux_channel)
      wait_idle(n);
      `CHK("conv_len", 1'b1, n inside {[396:404]})
      count_busy(1500, k);
      `CHK("single_stops", 0, k)
      rd(`OFS_RESULT0 + 8'h04, d, r);
      `CHK("single_data", 32'h0000_05A1, d)
      wr(`OFS_MODE, mw(2'h1, `MODE_MSINGLE));
      repeat (2) @(posedge sys_clk);
      `CHK("acq_sample", 1'b1, sample_on)
      wait_busy(n);
      `CHK("reissue_delay", 1'b1, n inside {[790:850]})
      wait_idle(n);
      rd(`OFS_RESULT0 + 8'h04, d, r);
      `CHK("reissue_data", 32'h0000_05A1, d)
      wr(`OFS_ACQ, 32'h0000_0000);
      wr(`OFS_PWRUP, 32'h0000_0000);
      wr(`OFS_MODE, mw(2'h0, `MODE_AWAKE));
      wr(`OFS_MODE, mw(2'h2, `MODE_MSCAN));
      for (int i = 0; i < 4; i++) begin
         wait_busy(n);
         if (i == 0) `CHK("scan_delay", 1'b1, n inside {[584:648]})
         `CHK("scan_order", 2'(i + 2), mux_channel)
         `CHK("ready_late", 1'b0, data_ready)
      end
      wait_idle(n);
      repeat (3) @(posedge sys_clk);
      `CHK("ready_done", 1'b1, data_ready)
      `CHK("int_ready", 1'b0, int_n)
      for (int i = 0; i < 4; i++) begin
         rd(`OFS_RESULT0 + 8'(4 * i), d, r);
         `CHK("scan_data", 32'h0000_05A0 + i, d)
      end
      // Auto scan from channel 3 with busy routed to the interrupt
      wr(`OFS_INTCFG, 32'h0000_0000);
      wr(`OFS_MODE, mw(2'h0, `MODE_AWAKE));
      wr(`OFS_MODE, mw(2'h3, `MODE_ASCAN));
      for (int i = 0; i < 6; i++) begin
         wait_busy(n);
         `CHK("auto_order", 2'(i + 3), mux_channel)
         repeat (2) @(posedge sys_clk);
         `CHK("int_busy", 1'b0, int_n)
      end
      wr(`OFS_MODE, mw(2'h0, `MODE_IDLE));
      count_busy(1500, k);
      `CHK("idle_quiet", 0, k)
      `CHK("idle_power", 1'b0, analog_power_on)
      rd(`OFS_RESULT0 + 8'h0C, d, r);
      `CHK("kept_data", 32'h0000_05A3, d)
      // Auto single, first halted by the alarm, then left running through it
      wr(`OFS_INTCFG, 32'h0000_0008);
      wr(`OFS_MODE, mw(2'h0, `MODE_AWAKE));
      wr(`OFS_MODE, mw(2'h0, `MODE_ASINGLE));
      wait_busy(n);
      `CHK("auto_chan", 2'h0, mux_channel)
      alarm_trip <= 1'b1;
      count_busy(2500, k);
      `CHK("alarm_halts", 0, k)
      wr(`OFS_INTCFG, 32'h0000_0000);
      wr(`OFS_MODE, mw(2'h0, `MODE_AWAKE));
      wr(`OFS_MODE, mw(2'h0, `MODE_ASINGLE));
      count_busy(3000, k);
      `CHK("alarm_runs", 1'b1, k >= 2)
      // Ready after each conversion of a manual scan, then the alarm on the interrupt
      wr(`OFS_INTCFG, 32'h0000_0005);
      wr(`OFS_MODE, mw(2'h0, `MODE_AWAKE));
      `CHK("ready_cleared", 1'b0, data_ready)
      wr(`OFS_MODE, mw(2'h0, `MODE_MSCAN));
      wait_busy(n);
      wait_idle(n);
      `CHK("ready_each", 1'b1, data_ready)
      wr(`OFS_INTCFG, 32'h0000_0002);
      `CHK("int_alarm", 1'b0, int_n)
      test_done;
   end
endmodule // adc_mode_sequencer_tb_top
